// ==== hw/sei_pkg.sv ====
// Constants shared by the servo-enable interlock design files.
// Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
package sei_pkg;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] SEI_OFS_CTRL = 8'h00;
    localparam logic [7:0] SEI_OFS_HOST = 8'h04;
    localparam logic [7:0] SEI_OFS_MASK = 8'h08;
    localparam logic [7:0] SEI_OFS_FAULT = 8'h0C;
    localparam logic [7:0] SEI_OFS_IRQ_STAT = 8'h10;
    localparam logic [7:0] SEI_OFS_IRQ_MASK = 8'h14;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int SEI_CTRL_SWITCH_BIT = 0;
    localparam int SEI_CTRL_FCLR_BIT = 1;
    localparam int SEI_HOST_PERMIT_BIT = 1;
    localparam int SEI_FAULT_CODE_LSB = 0;
    localparam int SEI_FAULT_AXIS_LSB = 8;
    localparam int SEI_IRQ_FAULT_BIT = 0;
    localparam int SEI_IRQ_PERMIT_LOST_BIT = 1;
    localparam int SEI_IRQ_FORCED_OFF_BIT = 2;
    localparam int SEI_IRQ_W = 3;

    // ------------------------------------------------------------
    // Widths, codes and reset values
    // ------------------------------------------------------------
    localparam int SEI_CODE_W = 8;
    localparam int SEI_HOST_W = 16;
    localparam int SEI_DATA_W = 32;
    localparam logic [SEI_CODE_W-1:0] SEI_CODE_NONE = 8'h00;
    localparam logic [SEI_CODE_W-1:0] SEI_CODE_MASK_MATCH = 8'h01;
    localparam logic [1:0] SEI_HTRANS_NONSEQ = 2'h2;
    localparam logic SEI_HRESP_OKAY = 1'b0;

endpackage

// ==== hw/sei_fault_if.sv ====
// Interface carrying per-axis fault matches to the interlock core.
// Assumes both ends share one clock; signals are plain levels.
`timescale 1ns/10ps
`default_nettype none

interface sei_fault_if #(
    parameter int NAXES = 8,
    parameter int AXW = 3
);
    logic [NAXES-1:0] hit;
    logic any_hit;
    logic [AXW-1:0] first_axis;

    modport det (
        output hit,
        output any_hit,
        output first_axis
    );
    modport ctl (
        input hit,
        input any_hit,
        input first_axis
    );
endinterface

`default_nettype wire

// ==== hw/sei_fault_detect.sv ====
// Per-axis comparison of condition words against the fault mask.
// Assumes synchronised condition words and a registered mask.
`timescale 1ns/10ps
`default_nettype none

module sei_fault_detect #(
    parameter int NAXES = 8,
    parameter int WORD_W = 16,
    parameter int AXW = 3
) (
    // Inputs
    input wire logic [NAXES*WORD_W-1:0] cond_words,
    input wire logic [WORD_W-1:0] mask,
    // Result
    sei_fault_if.det flt
);
    import sei_pkg::*;

    // ------------------------------------------------------------
    // Per-axis match
    // ------------------------------------------------------------
    // match per axis
    for (genvar a = 0; a < NAXES; a++)
    begin : g_axis
        assign flt.hit[a] = |(cond_words[a*WORD_W +: WORD_W] & mask);
    end

    assign flt.any_hit = |flt.hit;

    // ------------------------------------------------------------
    // Lowest matching axis wins on a tie
    // ------------------------------------------------------------
    always_comb
    begin
        flt.first_axis = '0;
        for (int i = NAXES - 1; i >= 0; i--)
        begin
            if (flt.hit[i])
            begin
                flt.first_axis = AXW'(i);
            end
        end
    end

endmodule // sei_fault_detect

`default_nettype wire

// ==== hw/sei_top.sv ====
// Servo-enable interlock: switch, host permit gating, axis fault latch.
// Assumes an AHB-Lite master on hclk; host word and axis words arrive
// from outside the clock domain and are resynchronised here.
//
// The AHB-Lite slave port and the address map were left to the implementer.
`timescale 1ns/10ps
`default_nettype none

module sei_top #(
    parameter int NAXES = 8,
    parameter int WORD_W = 16
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [sei_pkg::SEI_DATA_W-1:0] hwdata,
    input wire logic hready,
    output logic [sei_pkg::SEI_DATA_W-1:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Host processor control word
    input wire logic [sei_pkg::SEI_HOST_W-1:0] host_ctrl_word,
    // Axis condition words, axis 0 in the low bits
    input wire logic [NAXES*WORD_W-1:0] axis_condition_word,
    // Drive and status outputs
    output logic servo_on,
    output logic [sei_pkg::SEI_CODE_W-1:0] motion_fault_code,
    output logic [$clog2(NAXES)-1:0] first_faulting_axis,
    output logic irq
);
    import sei_pkg::*;

    localparam int AXW = $clog2(NAXES);

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [SEI_HOST_W-1:0] host_s1_q;
    logic [SEI_HOST_W-1:0] host_s2_q;
    logic [NAXES*WORD_W-1:0] axis_s1_q;
    logic [NAXES*WORD_W-1:0] axis_s2_q;

    // Words are status levels; a torn sample lasts one cycle at most
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            host_s1_q <= '0;
            host_s2_q <= '0;
            axis_s1_q <= '0;
            axis_s2_q <= '0;
        end
        else
        begin
            host_s1_q <= host_ctrl_word;
            host_s2_q <= host_s1_q;
            axis_s1_q <= axis_condition_word;
            axis_s2_q <= axis_s1_q;
        end
    end

    logic permit;
    logic permit_prev_q;

    assign permit = host_s2_q[SEI_HOST_PERMIT_BIT];

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            permit_prev_q <= 1'b0;
        end
        else
        begin
            permit_prev_q <= permit;
        end
    end

    // ------------------------------------------------------------
    // AHB-Lite address and data phase
    // ------------------------------------------------------------
    logic addr_valid;
    logic wr_pend_q;
    logic [7:0] wr_addr_q;
    logic [7:0] rd_addr;

    // Only whole-word transfers are defined; other sizes act as words
    assign addr_valid = hsel && hready && htrans[1];
    assign rd_addr = {haddr[7:2], 2'b00};
    assign hreadyout = 1'b1;
    assign hresp = SEI_HRESP_OKAY;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= '0;
        end
        else
        begin
            wr_pend_q <= addr_valid && hwrite;
            if (addr_valid)
            begin
                wr_addr_q <= rd_addr;
            end
        end
    end

    logic wr_ctrl;
    logic wr_mask;
    logic wr_irq_stat;
    logic wr_irq_mask;

    assign wr_ctrl = wr_pend_q && (wr_addr_q == SEI_OFS_CTRL);
    assign wr_mask = wr_pend_q && (wr_addr_q == SEI_OFS_MASK);
    assign wr_irq_stat = wr_pend_q && (wr_addr_q == SEI_OFS_IRQ_STAT);
    assign wr_irq_mask = wr_pend_q && (wr_addr_q == SEI_OFS_IRQ_MASK);

    // ------------------------------------------------------------
    // Fault mask register and detector
    // ------------------------------------------------------------
    logic [WORD_W-1:0] fault_select_mask_q;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            fault_select_mask_q <= '0;
        end
        else if (wr_mask)
        begin
            fault_select_mask_q <= hwdata[WORD_W-1:0];
        end
    end

    sei_fault_if #(.NAXES(NAXES), .AXW(AXW)) flt ();

    sei_fault_detect #(
        .NAXES(NAXES),
        .WORD_W(WORD_W),
        .AXW(AXW)
    ) u_detect (
        .cond_words(axis_s2_q),
        .mask(fault_select_mask_q),
        .flt(flt.det)
    );

    // ------------------------------------------------------------
    // Fault latch
    // ------------------------------------------------------------
    logic [SEI_CODE_W-1:0] fault_code_q;
    logic [SEI_CODE_W-1:0] fault_code_d;
    logic [AXW-1:0] fault_axis_q;
    logic [AXW-1:0] fault_axis_d;
    logic fault_clear;
    logic fault_new;

    assign fault_clear = wr_ctrl && hwdata[SEI_CTRL_FCLR_BIT];
    // A match in the clearing cycle re-latches at once
    assign fault_new = flt.any_hit && ((fault_code_q == SEI_CODE_NONE) || fault_clear);

    always_comb
    begin
        fault_code_d = fault_code_q;
        fault_axis_d = fault_axis_q;
        if (fault_clear)
        begin
            fault_code_d = SEI_CODE_NONE;
            fault_axis_d = '0;
        end
        if (fault_new)
        begin
            fault_code_d = SEI_CODE_MASK_MATCH;
            fault_axis_d = flt.first_axis;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            fault_code_q <= SEI_CODE_NONE;
            fault_axis_q <= '0;
        end
        else
        begin
            fault_code_q <= fault_code_d;
            fault_axis_q <= fault_axis_d;
        end
    end

    // ------------------------------------------------------------
    // Enable switch
    // ------------------------------------------------------------
    logic switch_q;
    logic switch_d;

    always_comb
    begin
        switch_d = switch_q;
        if (wr_ctrl)
        begin
            switch_d = hwdata[SEI_CTRL_SWITCH_BIT] && permit &&
                       (fault_code_q == SEI_CODE_NONE);
        end
        if (!permit)
        begin
            switch_d = 1'b0;
        end
        if (flt.any_hit)
        begin
            switch_d = 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            switch_q <= 1'b0;
        end
        else
        begin
            switch_q <= switch_d;
        end
    end

    assign servo_on = switch_q;
    assign motion_fault_code = fault_code_q;
    assign first_faulting_axis = fault_axis_q;

    // ------------------------------------------------------------
    // Interrupt status and mask
    // ------------------------------------------------------------
    logic [SEI_IRQ_W-1:0] irq_stat_q;
    logic [SEI_IRQ_W-1:0] irq_stat_d;
    logic [SEI_IRQ_W-1:0] irq_mask_q;
    logic [SEI_IRQ_W-1:0] irq_event;

    always_comb
    begin
        irq_event = '0;
        irq_event[SEI_IRQ_FAULT_BIT] = fault_new;
        irq_event[SEI_IRQ_PERMIT_LOST_BIT] = permit_prev_q && !permit;
        irq_event[SEI_IRQ_FORCED_OFF_BIT] = switch_q && (flt.any_hit || !permit);
        irq_stat_d = irq_stat_q;
        if (wr_irq_stat)
        begin
            irq_stat_d = irq_stat_q & ~hwdata[SEI_IRQ_W-1:0];
        end
        // New events win over a same-cycle clear
        irq_stat_d = irq_stat_d | irq_event;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            irq_stat_q <= '0;
            irq_mask_q <= '0;
        end
        else
        begin
            irq_stat_q <= irq_stat_d;
            if (wr_irq_mask)
            begin
                irq_mask_q <= hwdata[SEI_IRQ_W-1:0];
            end
        end
    end

    assign irq = |(irq_stat_q & irq_mask_q);

    // ------------------------------------------------------------
    // Read data, registered in the address phase
    // ------------------------------------------------------------
    logic [SEI_DATA_W-1:0] rdata_d;
    logic [SEI_DATA_W-1:0] rdata_q;

    always_comb
    begin
        rdata_d = '0;
        unique case (rd_addr)
            SEI_OFS_CTRL:
            begin
                rdata_d[SEI_CTRL_SWITCH_BIT] = switch_q;
            end
            SEI_OFS_HOST:
            begin
                rdata_d[SEI_HOST_W-1:0] = host_s2_q;
            end
            SEI_OFS_MASK:
            begin
                rdata_d[WORD_W-1:0] = fault_select_mask_q;
            end
            SEI_OFS_FAULT:
            begin
                rdata_d[SEI_FAULT_CODE_LSB +: SEI_CODE_W] = fault_code_q;
                rdata_d[SEI_FAULT_AXIS_LSB +: AXW] = fault_axis_q;
            end
            SEI_OFS_IRQ_STAT:
            begin
                rdata_d[SEI_IRQ_W-1:0] = irq_stat_q;
            end
            SEI_OFS_IRQ_MASK:
            begin
                rdata_d[SEI_IRQ_W-1:0] = irq_mask_q;
            end
            default:
            begin
                rdata_d = '0;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rdata_q <= '0;
        end
        else if (addr_valid && !hwrite)
        begin
            rdata_q <= rdata_d;
        end
    end

    assign hrdata = rdata_q;

endmodule // sei_top

`default_nettype wire

// ==== dv/sei_host_model.sv ====
// Host processor and axis status model facing the interlock.
// Assumes the bench requests permit and axis words; changes land on hclk.
`timescale 1ns/10ps
`default_nettype none
module sei_host_model #(
    parameter int NAXES = 8,
    parameter int WORD_W = 16
) (
    // Clock
    input wire logic hclk,
    // Bench requests
    input wire logic permit,
    input wire logic [NAXES*WORD_W-1:0] words_req,
    // Toward the interlock
    output logic [sei_pkg::SEI_HOST_W-1:0] host_ctrl_word,
    output logic [NAXES*WORD_W-1:0] axis_condition_word
);
    import sei_pkg::*;
    // ----
    // Host word, other bits never still
    // ----
    logic [13:0] cnt_q = 14'h0;
    always_ff @(posedge hclk)
    begin
        host_ctrl_word <= {cnt_q, permit, cnt_q[0]};
        cnt_q <= cnt_q + 14'h1;
        axis_condition_word <= words_req;
    end
endmodule // sei_host_model
`default_nettype wire

// ==== dv/sei_properties.sv ====
// Port-level checks of the servo-enable interlock.
// Assumes one clock and the single bus slave with aligned word addresses.
`timescale 1ns/10ps
`default_nettype none
module sei_properties #(
    parameter int NAXES = 8,
    parameter int WORD_W = 16
) (
    // Clock, reset, bus
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [sei_pkg::SEI_DATA_W-1:0] hwdata,
    input wire logic hready,
    input wire logic [sei_pkg::SEI_DATA_W-1:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // Host, axes, outputs
    input wire logic [sei_pkg::SEI_HOST_W-1:0] host_ctrl_word,
    input wire logic [NAXES*WORD_W-1:0] axis_condition_word,
    input wire logic servo_on,
    input wire logic [sei_pkg::SEI_CODE_W-1:0] motion_fault_code,
    input wire logic [$clog2(NAXES)-1:0] first_faulting_axis,
    input wire logic irq
);
    import sei_pkg::*;
    // ----
    // Helper: data-phase flags, mask shadow
    // ----
    logic take, ctl_q, rd_q, msk_q, hit;
    logic [WORD_W-1:0] mask_q;
    assign take = hsel && hready && htrans[1];
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ctl_q <= 1'b0;
            rd_q <= 1'b0;
            msk_q <= 1'b0;
            mask_q <= '0;
        end
        else
        begin
            if (msk_q)
                mask_q <= hwdata[WORD_W-1:0];
            ctl_q <= take && hwrite && haddr[7:0] == SEI_OFS_CTRL;
            rd_q <= take && !hwrite && haddr[7:0] == SEI_OFS_CTRL;
            msk_q <= take && hwrite && haddr[7:0] == SEI_OFS_MASK;
        end
    end
    always_comb
    begin
        hit = 1'b0;
        for (int a = 0; a < NAXES; a++)
            hit = hit | (|(axis_condition_word[a*WORD_W+:WORD_W] & mask_q));
    end
    // ----
    // Properties
    // ----
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_permit_lost;
        !host_ctrl_word[SEI_HOST_PERMIT_BIT] [*3];
    endsequence
    sequence s_hit_held;
        hit [*3];
    endsequence
    AST_RESET_STATE: assert property (disable iff (1'b0) !hresetn |-> !servo_on &&
        motion_fault_code == SEI_CODE_NONE && first_faulting_axis == '0)
        else $error("outputs not cleared in reset");
    AST_PERMIT_OFF: assert property (s_permit_lost |=> !servo_on)
        else $error("switch stays on without permit");
    AST_ON_NEEDS_PERMIT: assert property ($rose(servo_on) |->
        $past(host_ctrl_word[SEI_HOST_PERMIT_BIT], 3))
        else $error("switch on without permit");
    AST_ON_BY_WRITE: assert property ($rose(servo_on) |->
        $past(ctl_q && hwdata[SEI_CTRL_SWITCH_BIT]))
        else $error("switch on without a write");
    AST_SERVO_IS_SWITCH: assert property (rd_q |->
        hrdata[SEI_CTRL_SWITCH_BIT] == $past(servo_on))
        else $error("servo_on differs from switch");
    AST_FAULT_LATCH: assert property (s_hit_held |=>
        motion_fault_code == SEI_CODE_MASK_MATCH && !servo_on)
        else $error("mask match not latched");
    AST_FAULT_STICKY: assert property (motion_fault_code != SEI_CODE_NONE &&
        !(ctl_q && hwdata[SEI_CTRL_FCLR_BIT]) |=>
        motion_fault_code == SEI_CODE_MASK_MATCH && $stable(first_faulting_axis))
        else $error("fault record changed");
    AST_ON_NO_FAULT: assert property (servo_on |-> motion_fault_code == SEI_CODE_NONE)
        else $error("switch on with fault");
endmodule // sei_properties
bind sei_top sei_properties #(.NAXES(NAXES), .WORD_W(WORD_W)) u_props (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .host_ctrl_word(host_ctrl_word),
    .axis_condition_word(axis_condition_word), .servo_on(servo_on),
    .motion_fault_code(motion_fault_code), .first_faulting_axis(first_faulting_axis),
    .irq(irq));
`default_nettype wire

// ==== dv/sei_top_tb.sv ====
// Self-checking bench for the servo-enable interlock.
// Assumes the host model on the far side; reads are checked from a queue.
`timescale 1ns/10ps
`default_nettype none
module sei_top_tb;
    import sei_pkg::*;
    localparam int NAX = 8;
    localparam int WW = 16;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, servo_on, irq, permit, rd_dp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize, fax;
    logic [SEI_HOST_W-1:0] host_w;
    logic [NAX*WW-1:0] words, axw, w;
    logic [SEI_CODE_W-1:0] code;
    logic [WW-1:0] mask;
    logic [31:0] exp_q[$];
    int mismatches, n_tests, seed;
    sei_host_model #(.NAXES(NAX), .WORD_W(WW)) u_host (.hclk(hclk), .permit(permit),
        .words_req(words), .host_ctrl_word(host_w), .axis_condition_word(axw));
    sei_top #(.NAXES(NAX), .WORD_W(WW)) u_dut (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .host_ctrl_word(host_w), .axis_condition_word(axw),
        .servo_on(servo_on), .motion_fault_code(code), .first_faulting_axis(fax), .irq(irq));
    initial
    begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    // ----
    // Tasks
    // ----
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("checks=%0d mismatches=%0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic wait_rdy();
        int n;
        n = 0;
        do
        begin
            @(posedge hclk);
            n++;
        end
        while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1)
        begin
            mismatches++;
            report_and_stop();
        end
    endtask
    // For a read, d is the expected word
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= SEI_HTRANS_NONSEQ;
        hwrite <= wr;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        rd_dp <= !wr;
        if (!wr)
            exp_q.push_back(d);
        wait_rdy();
        rd_dp <= 1'b0;
    endtask
    // Covers the two-stage input sync plus the register edge
    task automatic settle();
        repeat (6) @(posedge hclk);
        #1;
    endtask
    always @(posedge hclk)
        if (rd_dp === 1'b1 && hreadyout === 1'b1)
        begin
            chk(hrdata, exp_q.pop_front());
            chk(hresp, SEI_HRESP_OKAY);
        end
    // ----
    // Main sequence
    // ----
    initial
    begin
        seed = 32'hB7D4;
        // Start high so the async reset sees a real falling edge
        hresetn = 1'b1;
        {hsel, haddr, htrans, hwrite, hwdata, permit, rd_dp} = '0;
        hsize = 3'h2;
        words = '0;
        mismatches = 0;
        n_tests = 0;
        #1 hresetn = 1'b0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        settle();
        chk({fax, code, irq, servo_on}, 32'h0);
        bus(1'b0, SEI_OFS_FAULT, 32'h0);
        bus(1'b0, 8'h20, 32'h0);
        bus(1'b1, SEI_OFS_IRQ_MASK, 32'h7);
        bus(1'b1, SEI_OFS_CTRL, 32'h1);
        bus(1'b0, SEI_OFS_CTRL, 32'h0);
        $display("test no_permit done");
        permit <= 1'b1;
        settle();
        bus(1'b1, SEI_OFS_CTRL, 32'h1);
        bus(1'b0, SEI_OFS_CTRL, 32'h1);
        chk(servo_on, 32'h1);
        bus(1'b1, SEI_OFS_CTRL, 32'h0);
        bus(1'b0, SEI_OFS_CTRL, 32'h0);
        bus(1'b1, SEI_OFS_CTRL, 32'h1);
        permit <= 1'b0;
        settle();
        chk(servo_on, 32'h0);
        bus(1'b0, SEI_OFS_IRQ_STAT, 32'h6);
        chk(irq, 32'h1);
        bus(1'b1, SEI_OFS_IRQ_STAT, 32'h7);
        settle();
        chk(irq, 32'h0);
        $display("test permit_loss done");
        permit <= 1'b1;
        mask = 16'($random(seed)) | 16'h1;
        bus(1'b1, SEI_OFS_MASK, {16'h0, mask});
        settle();
        for (int a = 0; a < NAX; a++)
        begin
            bus(1'b1, SEI_OFS_CTRL, 32'h1);
            bus(1'b0, SEI_OFS_CTRL, 32'h1);
            for (int b = 0; b < NAX; b++)
                w[b*WW+:WW] = 16'($random(seed)) & ~mask;
            w[a*WW+:WW] = 16'($random(seed)) | 16'h1;
            words <= w;
            settle();
            w[((a+3)%NAX)*WW+:WW] = 16'h1;
            words <= w;
            settle();
            chk(servo_on, 32'h0);
            chk({fax, code}, {a[2:0], SEI_CODE_MASK_MATCH});
            bus(1'b0, SEI_OFS_FAULT, {21'h0, a[2:0], SEI_CODE_MASK_MATCH});
            bus(1'b1, SEI_OFS_CTRL, 32'h1);
            bus(1'b0, SEI_OFS_CTRL, 32'h0);
            words <= '0;
            settle();
            bus(1'b1, SEI_OFS_CTRL, 32'h2);
            bus(1'b0, SEI_OFS_FAULT, 32'h0);
            chk({fax, code}, 32'h0);
        end
        // Fault and forced-off events stay latched until written back
        bus(1'b0, SEI_OFS_IRQ_STAT, 32'h5);
        chk(irq, 32'h1);
        $display("test axis_faults done");
        report_and_stop();
    end
endmodule // sei_top_tb
`default_nettype wire
